// *** hw/rtcc_top.v ***
// Functional notes
// (R1) 32-bit counter behind 10-bit prescaler
// (R2) 32-bit one compare; 16-bit two compares
// (R3) optional counter clear on compare match; code ignores it in calendar mode
// (R4) prescaler codes: off/1, then 2..64
// (R5) prescaler off: no periodic events
// (R6) read sync bit gates count reads
// (R7) tamper clears enabled general registers
// (R8) mode 3:2, enable 1, soft reset 0
// (R9) control enable-protected and write-synchronized
// (R10) daily event at last second
// (R11) tamper event captures calendar time
// (R12) overflow event when enabled
// (R13) calendar with 12/24 hour, leap years
// (R14) tamper timestamp: event, five pins, layer
// (R15) two general purpose registers
// (R16) wake on match, tick, overflow, input
// (R17) digital correction of prescaler rate
// (R18) software changes protected fields when disabled
// (R19) soft reset restores registers, disables block
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "rtcc_consts.vh"

module rtcc_top #(
    parameter PRESC_W = 10,
    parameter CORR_W  = 12,
    parameter NPIN    = 5
) (
    input  wire            i_core_clk,
    input  wire            i_arst_n,
    input  wire [5:0]      i_addr,
    input  wire [31:0]     i_wdata,
    input  wire            i_wr,
    input  wire            i_rd,
    output reg  [31:0]     o_rdata,
    input  wire            i_tamper_evt,
    input  wire [NPIN-1:0] i_tamper_pins,
    input  wire            i_layer_in,
    input  wire            i_wake,
    output reg             o_layer_out,
    output reg  [7:0]      o_periodic_evt,
    output reg  [1:0]      o_compare_evt,
    output reg             o_overflow_evt,
    output reg             o_daily_evt,
    output reg             o_wake,
    output wire            o_irq
);

    reg  [1:0]         mode_q;
    reg  [3:0]         presc_q;
    reg                en_q;
    reg                run_q;
    reg                sync_q;
    reg                tclr_q;
    reg                h12_q;
    reg                mclr_q;
    reg  [31:0]        evctl_q;
    reg  [31:0]        ctrlb_q;
    reg  [31:0]        cnt_q;
    reg  [31:0]        cmp0_q;
    reg  [15:0]        cmp1_q;
    reg  [7:0]         st_q;
    reg  [7:0]         mask_q;
    reg  [31:0]        gp_q [0:1];
    reg  [31:0]        tstamp_q;
    reg  [7:0]         corr_q;
    reg  [PRESC_W-1:0] pcnt_q;
    reg  [CORR_W-1:0]  ccnt_q;
    reg  [6:0]         crem_q;
    reg  [7:0]         lfsr_q;
    reg  [NPIN-1:0]    deb_q;
    reg  [NPIN-1:0]    deb_old_q;
    reg  [PRESC_W-1:0] div_mask;
    reg  [32:0]        cal_nx;
    reg  [31:0]        cnt_d;
    reg                ovf;
    reg                m0;
    reg                m1;

    wire               wr_ctrl  = i_wr & (i_addr == `RTCC_A_CTRL);
    wire               soft_clr = wr_ctrl & i_wdata[`RTCC_B_SOFT_RST]; // R19
    wire               prot_ok  = ~en_q; // R9
    wire               raw_tick;
    wire               adj;
    wire               tick;
    wire               presc_on = (presc_q != 4'h0);
    wire               layer_en = ctrlb_q[`RTCC_B_LAYER_EN];
    wire [NPIN-1:0]    rise;
    wire               mism;
    wire               tamper;
    wire               daily_now;
    wire [7:0]         per;
    wire [7:0]         st_set;
    wire [7:0]         st_clr;

    localparam [15:0]  CTRL_RST = `RTCC_RST_CTRL;

    // divide mask: tick when selected low bits are all ones
    always @*
    begin
        case (presc_q)
            4'h0, 4'h1: div_mask = 10'h000; // R4
            4'h2:       div_mask = 10'h001;
            4'h3:       div_mask = 10'h003;
            4'h4:       div_mask = 10'h007;
            4'h5:       div_mask = 10'h00f;
            4'h6:       div_mask = 10'h01f;
            default:    div_mask = 10'h03f;
        endcase
    end

    assign raw_tick = &(pcnt_q | ~div_mask); // R1
    // correction forces or suppresses one tick per pending step
    assign adj  = (crem_q != 7'h00) & (corr_q[7] ? raw_tick : ~raw_tick);
    assign tick = run_q & (raw_tick ^ adj); // R17

    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1)
        begin : g_per
            assign per[n] = run_q & presc_on & (&pcnt_q[n:0]) &
                            evctl_q[`RTCC_B_PER_LO + n]; // R5
        end
    endgenerate

    // calendar next second; bit 32 flags year wrap
    function [32:0] cal_next;
        input [31:0] t;
        input        h12;
        reg   [5:0]  s;
        reg   [5:0]  mi;
        reg   [4:0]  h;
        reg   [4:0]  d;
        reg   [3:0]  mo;
        reg   [5:0]  y;
        reg   [4:0]  dim;
        reg          nd;
        reg          wrap;
        begin
            s    = t[5:0];
            mi   = t[11:6];
            h    = t[16:12];
            d    = t[21:17];
            mo   = t[25:22];
            y    = t[31:26];
            nd   = 1'b0;
            wrap = 1'b0;
            case (mo)
                4'h2:                   dim = (y[1:0] == 2'h0) ?
                                              5'h1d : 5'h1c;
                4'h4, 4'h6, 4'h9, 4'hb: dim = 5'h1e;
                default:                dim = 5'h1f;
            endcase
            if (s == 6'h3b)
            begin
                s = 6'h00;
                if (mi == 6'h3b)
                begin
                    mi = 6'h00;
                    if (h12)
                    begin
                        if (h[3:0] == 4'hb)
                        begin
                            h[3:0] = 4'hc;
                            h[4]   = ~h[4];
                            nd     = ~h[4];
                        end
                        else if (h[3:0] == 4'hc)
                            h[3:0] = 4'h1;
                        else
                            h[3:0] = h[3:0] + 4'h1;
                    end
                    else if (h == 5'h17)
                    begin
                        h  = 5'h00;
                        nd = 1'b1;
                    end
                    else
                        h = h + 5'h01;
                end
                else
                    mi = mi + 6'h01;
            end
            else
                s = s + 6'h01;
            if (nd)
            begin
                if (d >= dim)
                begin
                    d = 5'h01;
                    if (mo >= 4'hc)
                    begin
                        mo   = 4'h1;
                        wrap = (y == 6'h3f);
                        y    = y + 6'h01;
                    end
                    else
                        mo = mo + 4'h1;
                end
                else
                    d = d + 5'h01;
            end
            cal_next = {wrap, y, mo, d, h, mi, s};
        end
    endfunction

    // next count, match and overflow
    always @*
    begin
        cal_nx = cal_next(cnt_q, h12_q); // R13
        cnt_d  = cnt_q;
        ovf    = 1'b0;
        m0     = 1'b0;
        m1     = 1'b0;
        case (mode_q)
            `RTCC_MODE_C16:
            begin
                m0    = (cnt_q[15:0] == cmp0_q[15:0]); // R2
                m1    = (cnt_q[15:0] == cmp1_q);
                ovf   = (cnt_q[15:0] == 16'hffff);
                cnt_d = {16'h0000, cnt_q[15:0] + 16'h0001};
                if (m0 & mclr_q)
                    cnt_d = 32'h00000000; // R3
            end
            `RTCC_MODE_CAL:
            begin
                m0    = (cnt_q == cmp0_q);
                ovf   = cal_nx[32];
                cnt_d = cal_nx[31:0];
            end
            default:
            begin
                m0    = (cnt_q == cmp0_q); // R2
                ovf   = (cnt_q == 32'hffffffff);
                cnt_d = cnt_q + 32'h00000001;
                if (m0 & mclr_q)
                    cnt_d = 32'h00000000; // R3
            end
        endcase
    end

    assign daily_now = (mode_q == `RTCC_MODE_CAL) &
                       (cal_nx[11:0] == {6'h3b, 6'h3b}) &
                       (h12_q ? (cal_nx[16:12] == 5'h1b) :
                                (cal_nx[16:12] == 5'h17)); // R10

    // tamper pins: debounce over three ticks
    generate
        for (n = 0; n < NPIN; n = n + 1)
        begin : g_deb
            reg [2:0] hist_q;
            always @(posedge i_core_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    hist_q   <= 3'h0;
                    deb_q[n] <= 1'b0;
                end
                else if (soft_clr)
                begin
                    hist_q   <= 3'h0;
                    deb_q[n] <= 1'b0;
                end
                else if (tick)
                begin
                    hist_q <= {hist_q[1:0], i_tamper_pins[n]};
                    if (hist_q == 3'h7)
                        deb_q[n] <= 1'b1;
                    else if (hist_q == 3'h0)
                        deb_q[n] <= 1'b0;
                end
            end
            assign rise[n] = deb_q[n] & ~deb_old_q[n] &
                             ctrlb_q[`RTCC_B_TPIN_LO + n]; // R14
        end
    endgenerate

    assign mism   = layer_en & tick & (i_layer_in != o_layer_out); // R14
    assign tamper = run_q & ((evctl_q[`RTCC_B_TAMP_EI] & i_tamper_evt) |
                             (|rise) | mism); // R11

    assign st_set = {2'b00,
                     tick & daily_now & evctl_q[`RTCC_B_DAILY_EO],
                     tamper,
                     |per,
                     tick & ovf,
                     tick & m1 & (mode_q == `RTCC_MODE_C16),
                     tick & m0};
    assign st_clr = (i_wr & (i_addr == `RTCC_A_STATUS)) ?
                    i_wdata[7:0] : 8'h00;
    assign o_irq  = |(st_q & mask_q);

    // register file, counter and prescaler
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            {sync_q, tclr_q, presc_q, mclr_q, h12_q, mode_q, en_q} <=
                {CTRL_RST[15:14], CTRL_RST[11:6], CTRL_RST[3:1]};
            run_q     <= 1'b0;
            evctl_q   <= `RTCC_RST_EVCTL;
            ctrlb_q   <= 32'h00000000;
            cnt_q     <= 32'h00000000;
            cmp0_q    <= 32'h00000000;
            cmp1_q    <= 16'h0000;
            st_q      <= 8'h00;
            mask_q    <= 8'h00;
            tstamp_q  <= 32'h00000000;
            corr_q    <= 8'h00;
            pcnt_q    <= {PRESC_W{1'b0}};
            ccnt_q    <= {CORR_W{1'b0}};
            crem_q    <= 7'h00;
            lfsr_q    <= `RTCC_RST_LFSR;
            deb_old_q <= {NPIN{1'b0}};
        end
        else if (soft_clr)
        begin
            {sync_q, tclr_q, presc_q, mclr_q, h12_q, mode_q, en_q} <=
                {CTRL_RST[15:14], CTRL_RST[11:6], CTRL_RST[3:1]}; // R19
            run_q     <= 1'b0;
            evctl_q   <= `RTCC_RST_EVCTL;
            ctrlb_q   <= 32'h00000000;
            cnt_q     <= 32'h00000000;
            cmp0_q    <= 32'h00000000;
            cmp1_q    <= 16'h0000;
            st_q      <= 8'h00;
            mask_q    <= 8'h00;
            tstamp_q  <= 32'h00000000;
            corr_q    <= 8'h00;
            pcnt_q    <= {PRESC_W{1'b0}};
            ccnt_q    <= {CORR_W{1'b0}};
            crem_q    <= 7'h00;
            lfsr_q    <= `RTCC_RST_LFSR;
            deb_old_q <= {NPIN{1'b0}};
        end
        else
        begin
            run_q     <= en_q; // R9
            deb_old_q <= deb_q;
            st_q      <= (st_q & ~st_clr) | st_set;
            if (run_q)
            begin
                pcnt_q <= pcnt_q + {{(PRESC_W-1){1'b0}}, 1'b1};
                ccnt_q <= ccnt_q + {{(CORR_W-1){1'b0}}, 1'b1};
                if (&ccnt_q)
                    crem_q <= corr_q[6:0]; // R17
                else if (adj)
                    crem_q <= crem_q - 7'h01;
            end
            if (tick & layer_en)
                lfsr_q <= {lfsr_q[6:0],
                           lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            if (tamper)
                tstamp_q <= cnt_q; // R11
            if (i_wr & (i_addr == `RTCC_A_COUNT))
                cnt_q <= i_wdata;
            else if (tick)
                cnt_q <= cnt_d; // R1
            if (wr_ctrl)
            begin
                en_q   <= i_wdata[`RTCC_B_ENABLE]; // R8
                sync_q <= i_wdata[`RTCC_B_RD_SYNC]; // R6
                if (prot_ok)
                begin
                    tclr_q  <= i_wdata[`RTCC_B_TAMP_CLR]; // R7
                    presc_q <= i_wdata[`RTCC_B_PRESC_LO +: 4];
                    mclr_q  <= i_wdata[`RTCC_B_MATCH_CLR];
                    h12_q   <= i_wdata[`RTCC_B_TWELVE];
                    mode_q  <= i_wdata[`RTCC_B_MODE_LO +: 2]; // R8
                end
            end
            if (i_wr & prot_ok)
            begin
                if (i_addr == `RTCC_A_EVCTL)
                    evctl_q <= i_wdata & `RTCC_EVCTL_MASK; // R18
                if (i_addr == `RTCC_A_CTRLB)
                    ctrlb_q <= i_wdata & `RTCC_CTRLB_MASK;
            end
            if (i_wr & (i_addr == `RTCC_A_CMP0))
                cmp0_q <= i_wdata;
            if (i_wr & (i_addr == `RTCC_A_CMP1))
                cmp1_q <= i_wdata[15:0];
            if (i_wr & (i_addr == `RTCC_A_MASK))
                mask_q <= i_wdata[7:0];
            if (i_wr & (i_addr == `RTCC_A_CORR))
                corr_q <= i_wdata[7:0];
        end
    end

    // general purpose registers
    generate
        for (n = 0; n < 2; n = n + 1)
        begin : g_gp
            wire [5:0] gp_addr = (n == 0) ? `RTCC_A_GP0 : `RTCC_A_GP1;
            always @(posedge i_core_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    gp_q[n] <= 32'h00000000;
                else if (soft_clr)
                    gp_q[n] <= 32'h00000000;
                else if (tamper & tclr_q &
                         ctrlb_q[`RTCC_B_GP_HOLD_LO + n])
                    gp_q[n] <= 32'h00000000; // R7
                else if (i_wr & (i_addr == gp_addr))
                    gp_q[n] <= i_wdata; // R15
            end
        end
    endgenerate

    // event outputs, wake and read data
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_periodic_evt <= 8'h00;
            o_compare_evt  <= 2'h0;
            o_overflow_evt <= 1'b0;
            o_daily_evt    <= 1'b0;
            o_wake         <= 1'b0;
            o_layer_out    <= 1'b0;
            o_rdata        <= 32'h00000000;
        end
        else
        begin
            o_periodic_evt <= per;
            o_compare_evt  <= {st_set[`RTCC_S_CMP1] &
                               evctl_q[`RTCC_B_CMP1_EO],
                               st_set[`RTCC_S_CMP0] &
                               evctl_q[`RTCC_B_CMP0_EO]};
            o_overflow_evt <= st_set[`RTCC_S_OVF] &
                              evctl_q[`RTCC_B_OVF_EO]; // R12
            o_daily_evt    <= st_set[`RTCC_S_DAILY]; // R10
            o_wake         <= i_wake | (|st_set[3:0]); // R16
            o_layer_out    <= layer_en & lfsr_q[0];
            o_rdata        <= 32'h00000000;
            if (i_rd)
            begin
                case (i_addr)
                    `RTCC_A_CTRL:   o_rdata <= {16'h0000, sync_q, tclr_q,
                                                2'b00, presc_q, mclr_q,
                                                h12_q, 2'b00, mode_q,
                                                en_q, 1'b0};
                    `RTCC_A_EVCTL:  o_rdata <= evctl_q;
                    `RTCC_A_COUNT:  o_rdata <= sync_q ? cnt_q :
                                               32'h00000000; // R6
                    `RTCC_A_CMP0:   o_rdata <= cmp0_q;
                    `RTCC_A_CMP1:   o_rdata <= {16'h0000, cmp1_q};
                    `RTCC_A_STATUS: o_rdata <= {24'h000000,
                                                en_q ^ run_q, st_q[6:0]};
                    `RTCC_A_MASK:   o_rdata <= {24'h000000, mask_q};
                    `RTCC_A_GP0:    o_rdata <= gp_q[0];
                    `RTCC_A_GP1:    o_rdata <= gp_q[1];
                    `RTCC_A_CTRLB:  o_rdata <= ctrlb_q;
                    `RTCC_A_TSTAMP: o_rdata <= tstamp_q;
                    `RTCC_A_CORR:   o_rdata <= {24'h000000, corr_q};
                    default:        o_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// *** hw/rtcc_consts.vh ***
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH

// register byte offsets
`define RTCC_A_CTRL        6'h00
`define RTCC_A_EVCTL       6'h04
`define RTCC_A_COUNT       6'h08
`define RTCC_A_CMP0        6'h0c
`define RTCC_A_CMP1        6'h10
`define RTCC_A_STATUS      6'h14
`define RTCC_A_MASK        6'h18
`define RTCC_A_GP0         6'h1c
`define RTCC_A_GP1         6'h20
`define RTCC_A_CTRLB       6'h24
`define RTCC_A_TSTAMP      6'h28
`define RTCC_A_CORR        6'h2c

// control fields
`define RTCC_B_SOFT_RST    0
`define RTCC_B_ENABLE      1
`define RTCC_B_MODE_LO     2
`define RTCC_B_TWELVE      6
`define RTCC_B_MATCH_CLR   7
`define RTCC_B_PRESC_LO    8
`define RTCC_B_TAMP_CLR    14
`define RTCC_B_RD_SYNC     15

// mode codes
`define RTCC_MODE_C32      2'h0
`define RTCC_MODE_C16      2'h1
`define RTCC_MODE_CAL      2'h2

// event control fields
`define RTCC_B_PER_LO      0
`define RTCC_B_CMP0_EO     8
`define RTCC_B_CMP1_EO     9
`define RTCC_B_OVF_EO      15
`define RTCC_B_TAMP_EI     16
`define RTCC_B_DAILY_EO    24
`define RTCC_EVCTL_MASK    32'h010183ff

// control B fields
`define RTCC_B_GP_HOLD_LO  0
`define RTCC_B_TPIN_LO     8
`define RTCC_B_LAYER_EN    15
`define RTCC_CTRLB_MASK    32'h00009f03

// status bits
`define RTCC_S_CMP0        0
`define RTCC_S_CMP1        1
`define RTCC_S_OVF         2
`define RTCC_S_PER         3
`define RTCC_S_TAMP        4
`define RTCC_S_DAILY       5
`define RTCC_S_BUSY        7

// reset values
`define RTCC_RST_CTRL      16'h0000
`define RTCC_RST_EVCTL     32'h00000000
`define RTCC_RST_LFSR      8'h01

`endif

// *** verification/rtcc_properties.sv ***
`timescale 1ns/1ps
module rtcc_checker (
    input wire        i_core_clk,
    input wire        i_arst_n,
    input wire [5:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        i_wake,
    input wire [7:0]  o_periodic_evt,
    input wire [1:0]  o_compare_evt,
    input wire        o_overflow_evt,
    input wire        o_daily_evt,
    input wire        o_wake,
    input wire        o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    a_reset_quiet: assert property (
        !$past(i_arst_n) |-> !o_irq && !o_wake && o_rdata == 32'h0)
        else $error("outputs active after reset");
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read slot");
    a_ctrl_bit0: assert property (
        $past(i_rd) && $past(i_addr) == 6'h00
        |-> !o_rdata[0] && o_rdata[31:16] == 16'h0)
        else $error("control readback bad");
    a_unmapped_zero: assert property (
        $past(i_rd) && $past(i_addr) > 6'h2c |-> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_soft_rst: assert property (
        i_wr && i_addr == 6'h00 && i_wdata[0]
        ##2 i_rd && i_addr == 6'h00 |=> o_rdata == 32'h0)
        else $error("soft reset left control set");
    a_wake_follow: assert property (
        i_wake |=> o_wake)
        else $error("wake input not passed");
    a_wake_cause: assert property (
        (|o_compare_evt) || o_overflow_evt |-> o_wake)
        else $error("event without wake");
    a_periodic_gap: assert property (
        o_periodic_evt[0] |=> !o_periodic_evt[0])
        else $error("periodic bit0 not a pulse");
    a_ovf_single: assert property (
        o_overflow_evt |=> !o_overflow_evt)
        else $error("overflow event repeated");
    a_daily_once: assert property (
        o_daily_evt |=> !o_daily_evt [*8])
        else $error("daily event repeated");
endmodule

bind rtcc_top rtcc_checker u_chk (.i_core_clk, .i_arst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wake, .o_periodic_evt,
    .o_compare_evt, .o_overflow_evt, .o_daily_evt, .o_wake, .o_irq);

// *** verification/rtc_counter_calendar_control_test.sv ***
`timescale 1ns/1ps
`include "rtcc_consts.vh"
`define CHK(a, e) \
    begin \
        comparisons = comparisons + 1; \
        if ((a) !== (e)) \
        begin \
            errors = errors + 1; \
            $display("[FAIL] %0t got %h exp %h", $time, a, e); \
        end \
    end

module rtc_counter_calendar_control_test;
    reg         i_core_clk   = 1'b0;
    reg         i_arst_n     = 1'b0;
    reg  [5:0]  i_addr       = 6'h00;
    reg  [31:0] i_wdata      = 32'h0;
    reg         i_wr         = 1'b0;
    reg         i_rd         = 1'b0;
    reg         i_tamper_evt = 1'b0;
    reg         i_wake       = 1'b0;
    reg  [4:0]  i_tamper_pins = 5'h00;
    wire [31:0] o_rdata;
    wire        o_layer_out;
    wire [7:0]  o_periodic_evt;
    wire [1:0]  o_compare_evt;
    wire        o_overflow_evt;
    wire        o_daily_evt;
    wire        o_wake;
    wire        o_irq;
    wire [12:0] evs = {o_daily_evt, o_overflow_evt, o_compare_evt,
                       |o_periodic_evt, o_periodic_evt};
    integer     errors      = 0;
    integer     comparisons = 0;
    integer     cyc         = 0;
    integer     i;
    integer     n;
    reg  [31:0] v;
    reg  [31:0] w;

    rtcc_top #(.CORR_W(4)) dut (.i_core_clk, .i_arst_n, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tamper_evt,
        .i_tamper_pins, .i_layer_in(o_layer_out), .i_wake,
        .o_layer_out, .o_periodic_evt, .o_compare_evt, .o_overflow_evt,
        .o_daily_evt, .o_wake, .o_irq);

    initial forever #10 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors = errors + 1;
            results;
        end
    end

    task wr(input [5:0] a, input [31:0] d);
    begin
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    end
    endtask

    task rd(input [5:0] a);
    begin
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    end
    endtask

    // waits for event bit b, n = cycles waited, lim if none
    task wt(input integer b, input integer lim);
    begin
        n = 0;
        @(posedge i_core_clk);
        #1;
        while (evs[b] !== 1'b1 && n < lim)
        begin
            @(posedge i_core_clk);
            #1;
            n = n + 1;
        end
    end
    endtask

    task tamp;
    begin
        @(posedge i_core_clk);
        i_tamper_evt <= 1'b1;
        i_wake <= 1'b1;
        @(posedge i_core_clk);
        i_tamper_evt <= 1'b0;
        i_wake <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    end
    endtask

    task results;
    begin
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        rd(`RTCC_A_CTRL);
        `CHK(v, `RTCC_RST_CTRL)
        rd(`RTCC_A_EVCTL);
        `CHK(v, `RTCC_RST_EVCTL)
        rd(6'h3c);
        `CHK(v, 32'h0)
        wr(`RTCC_A_EVCTL, 32'hffffffff);
        rd(`RTCC_A_EVCTL);
        `CHK(v, `RTCC_EVCTL_MASK)
        wr(`RTCC_A_CTRL, 32'h0000cbc8);
        rd(`RTCC_A_CTRL);
        `CHK(v, 32'h0000cbc8)
        wr(`RTCC_A_CTRL, 32'h0000cbcb);
        rd(`RTCC_A_CTRL);
        `CHK(v, 32'h0)
        rd(`RTCC_A_EVCTL);
        `CHK(v, 32'h0)
        $display("register test done");
        wr(`RTCC_A_CTRL, 32'h2);
        wr(`RTCC_A_EVCTL, 32'h1);
        rd(`RTCC_A_EVCTL);
        `CHK(v, 32'h0)
        rd(`RTCC_A_COUNT);
        `CHK(v, 32'h0)
        wr(`RTCC_A_CTRL, 32'h8006);
        rd(`RTCC_A_CTRL);
        `CHK(v, 32'h8002)
        wr(`RTCC_A_CTRL, 32'h0);
        $display("protection test done");
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`RTCC_A_CTRL, 32'h8002 | (i << 8));
            rd(`RTCC_A_COUNT);
            w = v;
            repeat (62) @(posedge i_core_clk);
            rd(`RTCC_A_COUNT);
            `CHK(v - w, 32'd64 >> (i == 0 ? 0 : i - 1))
            wr(`RTCC_A_CTRL, 32'h0);
        end
        $display("prescaler test done");
        wr(`RTCC_A_EVCTL, 32'hff);
        wr(`RTCC_A_CTRL, 32'h0102);
        for (i = 0; i < 8; i = i + 1)
        begin
            wt(i, 300);
            wt(i, 300);
            `CHK(n, (2 << i) - 1)
        end
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_CTRL, 32'h2);
        wt(8, 200);
        `CHK(n, 200)
        $display("periodic test done");
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_EVCTL, 32'h100);
        wr(`RTCC_A_COUNT, 32'h0);
        wr(`RTCC_A_CMP0, 32'h5);
        wr(`RTCC_A_STATUS, 32'hff);
        wr(`RTCC_A_MASK, 32'h1);
        wr(`RTCC_A_CTRL, 32'h8182);
        wt(9, 100);
        `CHK(o_wake, 1'b1)
        `CHK(o_irq, 1'b1)
        rd(`RTCC_A_COUNT);
        `CHK(v < 32'h6, 1'b1)
        wr(`RTCC_A_MASK, 32'h0);
        `CHK(o_irq, 1'b0)
        wr(`RTCC_A_MASK, 32'h1);
        `CHK(o_irq, 1'b1)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_STATUS, 32'hff);
        `CHK(o_irq, 1'b0)
        wr(`RTCC_A_CMP1, 32'h3);
        wr(`RTCC_A_COUNT, 32'h0);
        wr(`RTCC_A_EVCTL, 32'h200);
        wr(`RTCC_A_CTRL, 32'h0106);
        wt(10, 100);
        `CHK(n < 100, 1'b1)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_COUNT, 32'hfffe);
        wr(`RTCC_A_CTRL, 32'h0106);
        wt(11, 40);
        `CHK(n, 40)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_COUNT, 32'hfffe);
        wr(`RTCC_A_EVCTL, 32'h8000);
        wr(`RTCC_A_CTRL, 32'h0106);
        wt(11, 40);
        `CHK(n < 40, 1'b1)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_COUNT, 32'hfffffffe);
        wr(`RTCC_A_CTRL, 32'h0102);
        wt(11, 40);
        `CHK(n < 40, 1'b1)
        $display("compare test done");
        // leap-year february 28, one second before the daily event
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(`RTCC_A_CTRL, 32'h0);
            wr(`RTCC_A_EVCTL, 32'h01000000);
            wr(`RTCC_A_COUNT, i ? 32'h10b9befa : 32'h10b97efa);
            wr(`RTCC_A_CTRL, 32'h870a | (i << 6));
            wt(12, 200);
            `CHK(n < 200, 1'b1)
            rd(`RTCC_A_COUNT);
            `CHK(v, i ? 32'h10b9befb : 32'h10b97efb)
            repeat (64) @(posedge i_core_clk);
            rd(`RTCC_A_COUNT);
            `CHK(v, i ? 32'h10bac000 : 32'h10ba0000)
        end
        $display("calendar test done");
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_GP0, 32'ha5a5a5a5);
        wr(`RTCC_A_GP1, 32'h5a5a5a5a);
        rd(`RTCC_A_GP1);
        `CHK(v, 32'h5a5a5a5a)
        wr(`RTCC_A_CTRLB, 32'h1);
        wr(`RTCC_A_EVCTL, 32'h0);
        wr(`RTCC_A_STATUS, 32'hff);
        wr(`RTCC_A_CTRL, 32'h4102);
        tamp;
        rd(`RTCC_A_STATUS);
        `CHK(v[4], 1'b0)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_EVCTL, 32'h10000);
        wr(`RTCC_A_COUNT, 32'h12340000);
        wr(`RTCC_A_CTRL, 32'h4102);
        tamp;
        rd(`RTCC_A_STATUS);
        `CHK(v[4], 1'b1)
        rd(`RTCC_A_TSTAMP);
        `CHK(v[31:8], 24'h123400)
        rd(`RTCC_A_GP0);
        `CHK(v, 32'h0)
        rd(`RTCC_A_GP1);
        `CHK(v, 32'h5a5a5a5a)
        wr(`RTCC_A_CTRL, 32'h0);
        wr(`RTCC_A_CTRLB, 32'h100);
        wr(`RTCC_A_STATUS, 32'hff);
        wr(`RTCC_A_CTRL, 32'h0102);
        @(posedge i_core_clk) i_tamper_pins <= 5'h01;
        repeat (8) @(posedge i_core_clk);
        rd(`RTCC_A_STATUS);
        `CHK(v[4], 1'b1)
        // slow correction drops ticks, fast correction adds them
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(`RTCC_A_CTRL, 32'h0);
            wr(`RTCC_A_CORR, i ? 32'h01 : 32'h81);
            wr(`RTCC_A_CTRL, i ? 32'h8702 : 32'h8102);
            rd(`RTCC_A_COUNT);
            w = v;
            repeat (62) @(posedge i_core_clk);
            rd(`RTCC_A_COUNT);
            `CHK(i ? v - w > 32'd1 : v - w < 32'd64, 1'b1)
        end
        $display("tamper and correction test done");
        results;
    end
endmodule
